// ---- src/queue_status_registers.sv ----
// host-visible transmit space and receive header status registers
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module queue_status_registers #(
    parameter int HDR_DEPTH       = 4,
    parameter int CTRL_WORD_BYTES = 4
) (
    input  wire logic                                clock,
    input  wire logic                                reset,
    input  wire queue_status_pkg::reg_req_s          reg_req,
    output logic [queue_status_pkg::DATA_W-1:0]      rd_data,
    input  wire logic                                tx_alloc,
    input  wire logic [queue_status_pkg::TX_FREE_W-1:0] tx_alloc_len,
    input  wire logic                                tx_release,
    input  wire logic [queue_status_pkg::TX_FREE_W-1:0] tx_release_len,
    input  wire logic                                rx_done,
    input  wire queue_status_pkg::rx_frame_info_s    rx_info,
    output logic [$clog2(HDR_DEPTH+1)-1:0]           rx_frame_counter,
    output logic                                     irq
);
    import queue_status_pkg::*;

    localparam int CNT_W = $clog2(HDR_DEPTH+1);

    // ==========================================================
    // elaboration checks
    if (CTRL_WORD_BYTES < 1 || CTRL_WORD_BYTES > 64) begin : g_bad_ctrl
        $error("control word size out of range");
    end

    // ==========================================================
    // address decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    wire rd_tx    = reg_req.rd && hit(reg_req.addr, TX_FREE_OFF);
    wire rd_st    = reg_req.rd && hit(reg_req.addr, RX_STATUS_OFF);
    wire rd_bc    = reg_req.rd && hit(reg_req.addr, RX_COUNT_OFF);
    wire rd_irq   = reg_req.rd && hit(reg_req.addr, IRQ_STATUS_OFF);
    wire rd_mask  = reg_req.rd && hit(reg_req.addr, IRQ_MASK_OFF);
    wire rd_ctrl  = reg_req.rd && hit(reg_req.addr, CONTROL_OFF);
    wire wr_mask  = reg_req.wr && hit(reg_req.addr, IRQ_MASK_OFF);
    wire wr_ctrl  = reg_req.wr && hit(reg_req.addr, CONTROL_OFF);

    // ==========================================================
    // state
    logic [TX_FREE_W-1:0] tx_free_q;
    logic [TX_FREE_W-1:0] tx_free_d;
    logic [IRQ_W-1:0]     irq_status_q;
    logic [IRQ_W-1:0]     irq_status_d;
    logic [IRQ_W-1:0]     irq_mask_q;
    logic                 pass_bad_q;
    logic [DATA_W-1:0]    rd_data_q;
    logic [DATA_W-1:0]    rd_data_d;

    // ==========================================================
    // transmit queue space
    localparam logic [TX_FREE_W-1:0] CTRL_BYTES = TX_FREE_W'(CTRL_WORD_BYTES);

    // each frame costs its payload plus its control word
    wire [TX_FREE_W:0] alloc_cost =
        tx_alloc ? ({1'b0, tx_alloc_len} + {1'b0, CTRL_BYTES}) : '0;
    wire [TX_FREE_W:0] release_cost =
        tx_release ? ({1'b0, tx_release_len} + {1'b0, CTRL_BYTES}) : '0;

    // signed balance, clamped to the queue size
    wire [TX_FREE_W+1:0] tx_sum =
        {2'b00, tx_free_q} + {1'b0, release_cost} - {1'b0, alloc_cost};
    wire tx_under = tx_sum[TX_FREE_W+1];
    wire tx_over  = !tx_under && (tx_sum[TX_FREE_W:0] > {1'b0, TX_FREE_RESET});

    always_comb begin
        if (tx_under) begin
            tx_free_d = '0;
        end else if (tx_over) begin
            tx_free_d = TX_FREE_RESET;
        end else begin
            tx_free_d = tx_sum[TX_FREE_W-1:0];
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tx_free_q <= TX_FREE_RESET;
        end else begin
            tx_free_q <= tx_free_d;
        end
    end

    // ==========================================================
    // receive frame classification
    wire da_bcast = (rx_info.dest_addr == BCAST_ADDR);
    wire da_mcast = rx_info.dest_addr[DA_GROUP];
    wire is_bad   = rx_info.runt || rx_info.crc_err;

    // bad frames reach the host only when passing is enabled
    wire rx_keep  = rx_done && (!is_bad || pass_bad_q);

    rx_header_s  new_hdr;
    logic [15:0] new_status;

    always_comb begin
        new_status           = '0;
        new_status[ST_ICMP]  = rx_info.icmp_bad;
        new_status[ST_IP]    = rx_info.ip_bad;
        new_status[ST_TCP]   = rx_info.tcp_bad;
        new_status[ST_UDP]   = rx_info.udp_bad;
        new_status[ST_BCAST] = da_bcast;
        new_status[ST_MCAST] = da_mcast || da_bcast;
        new_status[ST_UCAST] = !da_mcast && !da_bcast;
        new_status[ST_ETYPE] = rx_info.len_type > ETYPE_MIN;
        new_status[ST_RUNT]  = rx_info.runt;
        new_status[ST_CRC]   = rx_info.crc_err;
        new_hdr.status       = new_status;
        new_hdr.byte_size    = rx_info.byte_size;
    end

    // ==========================================================
    // per-frame header store, popped by a byte count read
    rx_header_s     head;
    logic           hdr_empty;
    logic           hdr_full;
    logic [CNT_W-1:0] hdr_count;

    wire hdr_push = rx_keep && !hdr_full;
    wire hdr_pop  = rd_bc && !hdr_empty;
    wire rx_drop  = rx_done && !hdr_push;

    rx_header_store #(
        .DEPTH      (HDR_DEPTH)
    ) u_store (
        .clock      (clock),
        .reset      (reset),
        .push       (hdr_push),
        .push_entry (new_hdr),
        .pop        (hdr_pop),
        .head       (head),
        .count      (hdr_count),
        .empty      (hdr_empty),
        .full       (hdr_full)
    );

    assign rx_frame_counter = hdr_count;

    // ==========================================================
    // read data views
    wire [DATA_W-1:0] tx_view = {3'h0, tx_free_q};
    wire [DATA_W-1:0] st_view =
        hdr_empty ? '0
                  : ((head.status | (16'h0001 << ST_VALID)) & STATUS_USED);
    wire [DATA_W-1:0] bc_view =
        hdr_empty ? '0 : {4'h0, head.byte_size};
    wire [DATA_W-1:0] irq_view  = {13'h0, irq_status_q};
    wire [DATA_W-1:0] mask_view = {13'h0, irq_mask_q};
    wire [DATA_W-1:0] ctrl_view = {15'h0, pass_bad_q};

    // read mux; unmapped addresses answer zero
    always_comb begin
        rd_data_d = '0;
        if (rd_tx) begin
            rd_data_d = tx_view;
        end else if (rd_st) begin
            rd_data_d = st_view;
        end else if (rd_bc) begin
            rd_data_d = bc_view;
        end else if (rd_irq) begin
            rd_data_d = irq_view;
        end else if (rd_mask) begin
            rd_data_d = mask_view;
        end else if (rd_ctrl) begin
            rd_data_d = ctrl_view;
        end
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data = rd_data_q;

    // ==========================================================
    // control and mask writes; other writes are ignored
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_mask_q <= IRQ_MASK_RST;
            pass_bad_q <= 1'b0;
        end else begin
            if (wr_mask) begin
                irq_mask_q <= reg_req.wdata[IRQ_W-1:0];
            end
            if (wr_ctrl) begin
                pass_bad_q <= reg_req.wdata[CTRL_PASS_BAD];
            end
        end
    end

    // ==========================================================
    // sticky events; a new event beats the read clear
    wire [IRQ_W-1:0] irq_events = {rx_drop, tx_release, hdr_push};

    always_comb begin
        irq_status_d = irq_status_q;
        if (rd_irq) begin
            irq_status_d = '0;
        end
        irq_status_d = irq_status_d | irq_events;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    assign irq = |(irq_status_q & irq_mask_q);

    // ==========================================================
    // checks
    a_tx_free_range: assert property (@(posedge clock) disable iff (reset)
        tx_free_q <= TX_FREE_RESET)
        else $error("transmit free space above queue size");

    a_tx_alloc_cost: assert property (@(posedge clock) disable iff (reset)
        (tx_alloc && !tx_release && !tx_under)
        |=> tx_free_q == $past(tx_free_q) - $past(tx_alloc_len) - CTRL_BYTES)
        else $error("allocation did not charge payload plus control word");

    a_valid_empty: assert property (@(posedge clock) disable iff (reset)
        (rd_st && hdr_empty) |=> rd_data == 16'h0000)
        else $error("status valid with no frame pending");

    a_valid_pending: assert property (@(posedge clock) disable iff (reset)
        (rd_st && !hdr_empty) |=> rd_data[ST_VALID])
        else $error("status valid clear with a frame pending");

    a_rsvd_zero: assert property (@(posedge clock) disable iff (reset)
        (rd_st || rd_bc) |=> (rd_data & ~(STATUS_USED | COUNT_USED) & 16'h4314) == 16'h0000
            && (!$past(rd_bc) || rd_data[15:12] == 4'h0))
        else $error("reserved bits read nonzero");

    a_addr_class: assert property (@(posedge clock) disable iff (reset)
        hdr_push |-> (new_hdr.status[ST_UCAST] != new_hdr.status[ST_MCAST])
            && (!new_hdr.status[ST_BCAST] || new_hdr.status[ST_MCAST]))
        else $error("address class flags inconsistent");

    a_cksum_flags: assert property (@(posedge clock) disable iff (reset)
        hdr_push |-> new_hdr.status[ST_ICMP:ST_UDP]
            == {rx_info.icmp_bad, rx_info.ip_bad, rx_info.tcp_bad, rx_info.udp_bad})
        else $error("checksum flags misplaced");

    a_frame_type: assert property (@(posedge clock) disable iff (reset)
        (hdr_push && !rx_info.runt)
        |-> new_hdr.status[ST_ETYPE] == (rx_info.len_type > 16'h05DC))
        else $error("frame type flag wrong");

    a_bad_dropped: assert property (@(posedge clock) disable iff (reset)
        (rx_done && is_bad && !pass_bad_q) |-> !hdr_push ##1 irq_status_q[IRQ_RX_DROP])
        else $error("bad frame kept while passing disabled");

    a_pop_count: assert property (@(posedge clock) disable iff (reset)
        (rd_bc && !hdr_empty && !hdr_push)
        |=> rx_frame_counter == $past(rx_frame_counter) - CNT_W'(1))
        else $error("byte count read did not retire the frame");

    a_byte_count: assert property (@(posedge clock) disable iff (reset)
        (rd_bc && !hdr_empty) |=> rd_data == {4'h0, $past(head.byte_size)})
        else $error("byte count read wrong");

    // a read clear or a mask write in the next cycle may end the level
    a_irq_sticky: assert property (@(posedge clock) disable iff (reset)
        (hdr_push && irq_mask_q[IRQ_RX_FRAME] && !wr_mask)
        |=> irq ##1 (irq || $past(rd_irq || wr_mask)))
        else $error("receive event did not raise the interrupt");

    // transmit space view and its read-only behaviour
    a_tx_view: assert property (@(posedge clock) disable iff (reset)
        rd_tx |=> rd_data[15:13] == 3'h0 && rd_data[12:0] == $past(tx_free_q))
        else $error("transmit free space read wrong");

    a_tx_ro_write: assert property (@(posedge clock) disable iff (reset)
        (reg_req.wr && reg_req.addr == TX_FREE_OFF && !tx_alloc && !tx_release)
        |=> $stable(tx_free_q))
        else $error("write changed transmit free space");

    a_tx_release_credit: assert property (@(posedge clock) disable iff (reset)
        (tx_release && !tx_alloc && !tx_over)
        |=> tx_free_q == $past(tx_free_q) + $past(tx_release_len) + CTRL_BYTES)
        else $error("release did not credit payload plus control word");

    // header store occupancy
    a_count_push: assert property (@(posedge clock) disable iff (reset)
        (hdr_push && !hdr_pop)
        |=> rx_frame_counter == $past(rx_frame_counter) + CNT_W'(1))
        else $error("stored frame not counted");

    a_status_no_pop: assert property (@(posedge clock) disable iff (reset)
        (rd_st && !hdr_push) |=> $stable(rx_frame_counter))
        else $error("status read retired a frame");

    a_full_drop: assert property (@(posedge clock) disable iff (reset)
        (rx_done && hdr_full) |-> !hdr_push ##1 irq_status_q[IRQ_RX_DROP])
        else $error("frame taken into a full store");

    a_count_empty: assert property (@(posedge clock) disable iff (reset)
        (rd_bc && hdr_empty) |=> rd_data == 16'h0000)
        else $error("byte count nonzero with no frame pending");

    // interrupt and control registers
    a_irq_clear: assert property (@(posedge clock) disable iff (reset)
        (rd_irq && irq_events == '0) |=> irq_status_q == '0)
        else $error("interrupt status not cleared by read");

    a_mask_write: assert property (@(posedge clock) disable iff (reset)
        wr_mask |=> irq_mask_q == $past(reg_req.wdata[IRQ_W-1:0]))
        else $error("mask write not taken");

    a_pass_write: assert property (@(posedge clock) disable iff (reset)
        wr_ctrl |=> pass_bad_q == $past(reg_req.wdata[CTRL_PASS_BAD]))
        else $error("pass bad frame write not taken");

endmodule
`default_nettype wire

// ---- src/queue_status_pkg.sv ----
// constants and carrier types for the queue status register bank
package queue_status_pkg;

    // ==========================================================
    // register bus
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;

    localparam logic [ADDR_W-1:0] TX_FREE_OFF    = 9'h178;
    localparam logic [ADDR_W-1:0] RX_STATUS_OFF  = 9'h17C;
    localparam logic [ADDR_W-1:0] RX_COUNT_OFF   = 9'h17E;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFF = 9'h1A0;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFF   = 9'h1A2;
    localparam logic [ADDR_W-1:0] CONTROL_OFF    = 9'h1A4;

    // ==========================================================
    // transmit queue space
    localparam int               TX_FREE_W     = 13;
    localparam logic [12:0]      TX_FREE_RESET = 13'h1800;

    // ==========================================================
    // receive header status field positions
    localparam int BYTE_SIZE_W = 12;
    localparam int ST_VALID    = 15;
    localparam int ST_ICMP     = 13;
    localparam int ST_IP       = 12;
    localparam int ST_TCP      = 11;
    localparam int ST_UDP      = 10;
    localparam int ST_BCAST    = 7;
    localparam int ST_MCAST    = 6;
    localparam int ST_UCAST    = 5;
    localparam int ST_ETYPE    = 3;
    localparam int ST_RUNT     = 1;
    localparam int ST_CRC      = 0;

    localparam logic [15:0] STATUS_USED = 16'hBCEB;
    localparam logic [15:0] COUNT_USED  = 16'h0FFF;
    localparam logic [15:0] ETYPE_MIN   = 16'h05DC; // 1500
    localparam logic [47:0] BCAST_ADDR  = 48'hFFFF_FFFF_FFFF;
    localparam int          DA_GROUP    = 40;       // i/g bit of first octet

    // ==========================================================
    // interrupt and control bits
    localparam int          IRQ_W        = 3;
    localparam int          IRQ_RX_FRAME = 0;
    localparam int          IRQ_TX_SPACE = 1;
    localparam int          IRQ_RX_DROP  = 2;
    localparam logic [2:0]  IRQ_MASK_RST = 3'h0;
    localparam int          CTRL_PASS_BAD = 0;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic [47:0]            dest_addr;
        logic [15:0]            len_type;
        logic [BYTE_SIZE_W-1:0] byte_size;
        logic                   icmp_bad;
        logic                   ip_bad;
        logic                   tcp_bad;
        logic                   udp_bad;
        logic                   runt;
        logic                   crc_err;
    } rx_frame_info_s;

    typedef struct packed {
        logic [15:0]            status;
        logic [BYTE_SIZE_W-1:0] byte_size;
    } rx_header_s;

endpackage

// ---- src/rx_header_store.sv ----
// flip-flop queue of received frame headers
`timescale 1ns/1ps
`default_nettype none
module rx_header_store #(
    parameter int DEPTH = 4
) (
    input  wire logic                               clock,
    input  wire logic                               reset,
    input  wire logic                               push,
    input  wire queue_status_pkg::rx_header_s       push_entry,
    input  wire logic                               pop,
    output var  queue_status_pkg::rx_header_s       head,
    output logic [$clog2(DEPTH+1)-1:0]              count,
    output logic                                    empty,
    output logic                                    full
);
    import queue_status_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);

    // ==========================================================
    // elaboration check: pointers wrap by power of two
    if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH-1)) != 0) begin : g_bad_depth
        $error("rx_header_store depth must be a power of two from 2 to 16");
    end

    rx_header_s             mem_q [DEPTH];
    logic [PTR_W-1:0]       wr_ptr_q;
    logic [PTR_W-1:0]       rd_ptr_q;
    logic [CNT_W-1:0]       count_q;

    // ==========================================================
    // handshake qualification
    wire do_push = push && !full;
    wire do_pop  = pop && !empty;

    assign empty = (count_q == '0);
    assign full  = (count_q == CNT_W'(DEPTH));
    assign count = count_q;
    assign head  = mem_q[rd_ptr_q];

    // storage cells, one writer per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_cell
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                mem_q[i] <= '0;
            end else if (do_push && wr_ptr_q == PTR_W'(i)) begin
                mem_q[i] <= push_entry;
            end
        end
    end

    // pointers and occupancy
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + PTR_W'(do_push);
            rd_ptr_q <= rd_ptr_q + PTR_W'(do_pop);
            count_q  <= count_q + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end

endmodule
`default_nettype wire

// ---- verification/host_model.sv ----
// host bus master model driving the queue status register port
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                        clock,
    output var  queue_status_pkg::reg_req_s  reg_req,
    input  wire logic [15:0]                 rd_data,
    output logic                             tx_alloc,
    output logic [12:0]                      tx_alloc_len
);
    import queue_status_pkg::*;

    // ==========================================================
    // idle bus at time zero
    initial begin
        reg_req = '0;
        tx_alloc = 1'b0;
        tx_alloc_len = 13'h0000;
    end

    // one-cycle write strobe
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        reg_req.wr <= 1'b0;
    endtask

    // one-cycle read strobe; whole 16-bit word, so low byte never after high
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clock);
        reg_req.rd <= 1'b0;
        @(posedge clock);
        d = rd_data;
    endtask

    // place a frame only when free space covers payload and control word
    task automatic send_frame(input logic [12:0] len, output logic sent);
        logic [15:0] f;
        rd(TX_FREE_OFF, f);
        sent = (f[12:0] >= len + 13'h0004);
        if (sent) begin
            @(posedge clock);
            tx_alloc     <= 1'b1;
            tx_alloc_len <= len;
            @(posedge clock);
            tx_alloc <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ---- verification/queue_status_registers_tb.sv ----
// self-checking bench for the queue status register bank
`timescale 1ns/1ps
`default_nettype none
module queue_status_registers_tb;
    import queue_status_pkg::*;
    localparam int CTRL = 4;

    logic           clock;
    logic           reset;
    reg_req_s       reg_req;
    logic [15:0]    rd_data;
    logic           tx_alloc;
    logic [12:0]    tx_alloc_len;
    logic           tx_release;
    logic [12:0]    tx_release_len;
    logic           rx_done;
    rx_frame_info_s rx_info;
    logic [2:0]     rx_frame_counter;
    logic           irq;
    int             mismatches;
    int             n_checks;
    int             seed;
    int             exp_free;
    logic [2:0]     irq_st;
    logic [2:0]     mask;
    rx_header_s     q[$];

    // ==========================================================
    // device and host
    queue_status_registers #(.HDR_DEPTH(4), .CTRL_WORD_BYTES(CTRL)) dut (
        .clock(clock), .reset(reset), .reg_req(reg_req), .rd_data(rd_data),
        .tx_alloc(tx_alloc), .tx_alloc_len(tx_alloc_len), .tx_release(tx_release),
        .tx_release_len(tx_release_len), .rx_done(rx_done), .rx_info(rx_info),
        .rx_frame_counter(rx_frame_counter), .irq(irq)
    );
    host_model host (
        .clock(clock), .reg_req(reg_req), .rd_data(rd_data),
        .tx_alloc(tx_alloc), .tx_alloc_len(tx_alloc_len)
    );

    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // expected header status word
    function automatic logic [15:0] exp_status(input rx_frame_info_s f);
        logic [15:0] s;
        s = 16'h8000;
        s[13:10] = {f.icmp_bad, f.ip_bad, f.tcp_bad, f.udp_bad};
        s[7] = (f.dest_addr == 48'hFFFF_FFFF_FFFF);
        s[6] = f.dest_addr[40];
        s[5] = !f.dest_addr[40];
        s[3] = (f.len_type > 16'h05DC);
        s[1] = f.runt;
        s[0] = f.crc_err;
        return s;
    endfunction

    // hang guard
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        test_done();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [15:0]    d;
        logic [15:0]    m;
        logic           sent;
        logic           keep;
        logic [12:0]    len;
        logic [12:0]    last_len;
        logic [63:0]    r;
        rx_frame_info_s f;
        reset = 1'b1;
        tx_release = 1'b0;
        tx_release_len = 13'h0000;
        rx_done = 1'b0;
        rx_info = '0;
        mismatches = 0;
        n_checks = 0;
        seed = 48020;
        exp_free = 16'h1800;
        irq_st = 3'h0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        host.rd(TX_FREE_OFF, d);
        chk("tx free reset", 16'h1800, d);
        host.rd(RX_COUNT_OFF, d);
        chk("byte count empty", 16'h0000, d);
        host.wr(TX_FREE_OFF, 16'hFFFF);
        host.rd(TX_FREE_OFF, d);
        chk("tx free read only", 16'h1800, d);
        host.rd(9'h100, d);
        chk("unmapped read", 16'h0000, d);
        host.wr(IRQ_MASK_OFF, 16'h0007);
        host.rd(IRQ_MASK_OFF, d);
        chk("irq mask readback", 16'h0007, d);
        mask = 3'h7;
        // transmit space bookkeeping, host refuses when space is short
        for (int k = 0; k < 4; k++) begin
            len = 13'($random(seed)) & 13'h07FF;
            host.send_frame(len, sent);
            if (sent) begin
                exp_free -= len + CTRL;
                last_len = len;
            end
            host.rd(TX_FREE_OFF, d);
            chk("tx free alloc", 16'(exp_free), d);
        end
        @(posedge clock);
        tx_release <= 1'b1;
        tx_release_len <= last_len;
        @(posedge clock);
        tx_release <= 1'b0;
        exp_free += last_len + CTRL;
        host.rd(TX_FREE_OFF, d);
        chk("tx free release", 16'(exp_free), d);
        chk("irq raised", 16'h0001, {15'h0000, irq});
        host.rd(IRQ_STATUS_OFF, d);
        chk("irq status tx", 16'h0002, d);
        chk("irq cleared", 16'h0000, {15'h0000, irq});
        // receive headers, pass-bad off then on, interrupt masked then open
        for (int p = 0; p < 2; p++) begin
            mask = (p == 0) ? 3'h0 : 3'h7;
            host.wr(CONTROL_OFF, 16'(p));
            host.wr(IRQ_MASK_OFF, {13'h0000, mask});
            host.rd(CONTROL_OFF, d);
            chk("control readback", 16'(p), d);
            for (int k = 0; k < 6; k++) begin
                r = {$random(seed), $random(seed)};
                f.dest_addr = (k == 2) ? 48'hFFFF_FFFF_FFFF : r[47:0];
                f.len_type = 16'h05DB + 16'(k % 3);
                f.byte_size = r[59:48];
                {f.icmp_bad, f.ip_bad, f.tcp_bad, f.udp_bad} = r[63:60];
                f.runt = (k == 3);
                f.crc_err = (k == 4);
                keep = ((!f.runt && !f.crc_err) || p == 1) && q.size() < 4;
                @(posedge clock);
                rx_done <= 1'b1;
                rx_info <= f;
                @(posedge clock);
                rx_done <= 1'b0;
                if (keep) begin
                    q.push_back('{status: exp_status(f), byte_size: f.byte_size});
                    irq_st[0] = 1'b1;
                end else begin
                    irq_st[2] = 1'b1;
                end
                @(posedge clock);
                chk("frame count rx", 16'(q.size()), {13'h0000, rx_frame_counter});
            end
            chk("irq level", {15'h0000, |(irq_st & mask)}, {15'h0000, irq});
            host.rd(IRQ_STATUS_OFF, d);
            chk("irq status rx", {13'h0000, irq_st}, d);
            irq_st = 3'h0;
            while (q.size() > 0) begin
                m = q[0].status[1] ? 16'hFFF7 : 16'hFFFF;
                host.rd(RX_STATUS_OFF, d);
                chk("rx status", q[0].status & m, d & m);
                host.rd(RX_COUNT_OFF, d);
                chk("byte count", {4'h0, q[0].byte_size}, d);
                void'(q.pop_front());
                chk("frame count pop", 16'(q.size()), {13'h0000, rx_frame_counter});
            end
            host.rd(RX_STATUS_OFF, d);
            chk("rx status empty", 16'h0000, d);
        end
        test_done();
    end
endmodule
`default_nettype wire
